// ### src/nfc_ctrl.sv
// Host controller driving a NAND flash command port
// Operation
// - Bytes latched at write strobe rise, select low
// - Send column, low row, high row
// - Program: setup, address, data, confirm
// - Erase: setup, two row cycles, execute
// - Keep spare enable fixed during operations
// - Data out: latches low, toggle read strobe
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module nfc_ctrl
   import nfc_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   output logic                   cmd_latch,
   output logic                   addr_latch,
   output logic                   chip_sel_n,
   output logic                   write_strobe_n,
   output logic                   read_strobe_n,
   output logic                   write_prot_n,
   output logic                   spare_region_enable_n,
   input  wire logic [7:0]        shared_io_bus_in,
   output logic      [7:0]        shared_io_bus_out,
   output logic                   shared_io_bus_oe,
   input  wire logic              ready_busy_n
);
   import nfc_pkg::*;

   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_CMD  = 7'b0000010,
      ST_ADR  = 7'b0000100,
      ST_WAIT = 7'b0001000,
      ST_DIN  = 7'b0010000,
      ST_DOUT = 7'b0100000,
      ST_CONF = 7'b1000000
   } nfc_state_t;

   nfc_state_t         state;
   nfc_op_t            op;
   logic [ADDR_W-1:0]  addr;
   logic [PTR_W-1:0]   count;
   logic [PTR_W-1:0]   xfer_left;
   logic [PTR_W-1:0]   buf_ptr;
   logic [1:0]         adr_idx;
   logic               phase;
   logic [1:0]         phase_cnt;
   logic               second_cmd;
   logic               err;
   logic [15:0]        wait_cnt;
   logic [7:0]         mem_rd;
   logic               mem_we;
   logic [PTR_W-1:0]   next_buf_ptr;

   // Opcode that opens each operation
   function automatic logic [7:0] first_opcode(input nfc_op_t o, input logic half);
      unique case (o)
         HOP_READ:   first_opcode = half ? OP_READ_B : OP_READ_A;
         HOP_SPARE:  first_opcode = OP_READ_SP;
         HOP_IDENT:  first_opcode = OP_IDENT;
         HOP_PROG:   first_opcode = OP_PROG;
         HOP_ERASE:  first_opcode = OP_ERASE;
         HOP_STATUS: first_opcode = OP_STATUS;
         default:    first_opcode = OP_RESET;
      endcase
   endfunction

   wire       tick      = (phase_cnt == 2'(PHASE_CYC - 1));
   wire       busy      = (state != ST_IDLE);
   wire       wr_ctrl   = reg_wr && (reg_addr == REG_CTRL);
   wire [2:0] req_op    = reg_wdata[CTRL_OP_LSB +: CTRL_OP_W];
   wire       go        = wr_ctrl && reg_wdata[CTRL_GO] && !busy;
   wire       dev_ready = ready_busy_n;
   // Only reset and status may be issued while the device is busy
   wire       busy_ok   = (req_op == HOP_RESET) || (req_op == HOP_STATUS);
   wire       refuse    = go && !dev_ready && !busy_ok;
   // Spare read needs spare enable low; prog/erase need protect released
   wire       bad_sp    = (req_op == HOP_SPARE) && !reg_wdata[CTRL_SPARE];
   wire       bad_wp    = ((req_op == HOP_PROG) || (req_op == HOP_ERASE))
                          && !reg_wdata[CTRL_WP];
   wire       start     = go && !refuse && !bad_sp && !bad_wp;
   wire       has_addr  = (op == HOP_READ) || (op == HOP_SPARE) || (op == HOP_IDENT)
                          || (op == HOP_PROG) || (op == HOP_ERASE);
   wire [1:0] last_adr  = (op == HOP_IDENT) ? 2'h0 : 2'h2;
   // Erase skips the column cycle
   wire [1:0] first_adr = (op == HOP_ERASE) ? 2'h1 : 2'h0;
   wire [7:0] adr_byte  = (adr_idx == 2'h0) ? addr[7:0] :
                          (adr_idx == 2'h1) ? addr[16:9] :
                                              {2'h0, addr[22:17]};
   wire [7:0] cmd_byte  = second_cmd ? ((op == HOP_PROG) ? OP_PROG_GO : OP_ERASE_GO)
                                     : first_opcode(op, addr[ADDR_BIT8]);
   wire       reads     = (op != HOP_PROG) && (op != HOP_ERASE) && (op != HOP_RESET);
   // Settle delay first, so a busy line that falls late is not missed
   wire       wait_done = (wait_cnt >= 16'(RB_SETTLE_CYC)) && dev_ready;
   assign mem_we = (state == ST_DOUT) && phase && tick;
   // Memory reads the coming pointer, so back-to-back buffer reads stay fresh
   wire       sw_buf    = (reg_wr || reg_rd) && (reg_addr == REG_BUF) && !busy;
   wire       ptr_step  = (state == ST_DIN || state == ST_DOUT) && phase && tick;
   wire [PTR_W-1:0] ptr_inc = (buf_ptr == 10'(PAGE_BYTES - 1)) ? '0 : buf_ptr + 10'h1;
   assign next_buf_ptr = (sys_rst || start) ? '0
                       : ptr_step ? ptr_inc
                       : (reg_wr && reg_addr == REG_BUFPTR && !busy) ? reg_wdata[PTR_W-1:0]
                       : sw_buf ? ptr_inc : buf_ptr;
   nfc_page_mem u_mem (
      .sys_clk (sys_clk),
      .wr_en   (mem_we || (reg_wr && sw_buf)),
      .wr_addr (buf_ptr),
      .wr_data (mem_we ? shared_io_bus_in : reg_wdata[7:0]),
      .rd_addr (next_buf_ptr),
      .rd_data (mem_rd)
   );
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst || !busy || tick)
         phase_cnt <= 2'h0;
      else
         phase_cnt <= phase_cnt + 2'h1;
   end

   // Sequencer: each pin cycle is a low phase then a high phase
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state <= ST_IDLE; op <= HOP_RESET; phase <= 1'b0; adr_idx <= 2'h0;
         second_cmd <= 1'b0; wait_cnt <= 16'h0; xfer_left <= '0;
         cmd_latch <= 1'b0; addr_latch <= 1'b0; chip_sel_n <= 1'b1;
         write_strobe_n <= 1'b1; read_strobe_n <= 1'b1;
         shared_io_bus_out <= 8'h00; shared_io_bus_oe <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               chip_sel_n <= 1'b1;
               shared_io_bus_oe <= 1'b0;
               if (start)
               begin
                  op <= nfc_op_t'(req_op); second_cmd <= 1'b0; phase <= 1'b0;
                  xfer_left <= count; state <= ST_CMD; chip_sel_n <= 1'b0;
               end
            end
            ST_CMD:
            if (tick)
            begin
               // Opcode with command latch high, latched at strobe rise
               cmd_latch <= 1'b1; addr_latch <= 1'b0;
               shared_io_bus_out <= cmd_byte; shared_io_bus_oe <= 1'b1;
               write_strobe_n <= phase;
               phase <= !phase;
               if (phase)
               begin
                  adr_idx <= first_adr;
                  state <= (!second_cmd && has_addr) ? ST_ADR
                         : (op == HOP_STATUS) ? ST_DOUT : ST_WAIT;
               end
            end
            ST_ADR:
            if (tick)
            begin
               cmd_latch <= 1'b0; addr_latch <= 1'b1;
               shared_io_bus_out <= adr_byte;
               write_strobe_n <= phase;
               phase <= !phase;
               if (phase)
               begin
                  adr_idx <= adr_idx + 2'h1;
                  if (adr_idx == last_adr)
                     state <= (op == HOP_PROG) ? ST_DIN
                            : (op == HOP_ERASE) ? ST_CONF
                            : (op == HOP_IDENT) ? ST_DOUT : ST_WAIT;
               end
            end
            ST_DIN:
            if (tick)
            begin
               // Program data: both latches low
               addr_latch <= 1'b0; cmd_latch <= 1'b0;
               shared_io_bus_out <= mem_rd;
               write_strobe_n <= phase;
               phase <= !phase;
               if (phase)
               begin
                  xfer_left <= xfer_left - 10'h1;
                  if (xfer_left == 10'h1)
                     state <= ST_CONF;
               end
            end
            ST_CONF:
            begin
               second_cmd <= 1'b1;
               state <= ST_CMD;
            end
            ST_WAIT:
            begin
               // Chip select stays low only for reads; prog/erase ignore it
               cmd_latch <= 1'b0; addr_latch <= 1'b0; write_strobe_n <= 1'b1;
               shared_io_bus_oe <= 1'b0;
               chip_sel_n <= !reads;
               wait_cnt <= wait_cnt + 16'h1;
               if (wait_done)
               begin
                  wait_cnt <= 16'h0;
                  state <= (reads && op != HOP_RESET) ? ST_DOUT : ST_IDLE;
               end
            end
            ST_DOUT:
            if (tick)
            begin
               // Latches low, write strobe high, toggle read strobe
               cmd_latch <= 1'b0; addr_latch <= 1'b0;
               shared_io_bus_oe <= 1'b0; chip_sel_n <= 1'b0;
               read_strobe_n <= phase;
               phase <= !phase;
               if (phase)
               begin
                  xfer_left <= xfer_left - 10'h1;
                  if (xfer_left <= 10'h1)
                  begin
                     state <= ST_IDLE;
                     chip_sel_n <= 1'b1;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Buffer pointer: steps per data byte, software may reposition it
   always_ff @(posedge sys_clk) buf_ptr <= next_buf_ptr;

   // Software registers
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         addr <= '0; count <= 10'h1; err <= 1'b0; write_prot_n <= 1'b0;
         spare_region_enable_n <= 1'b1; reg_rdata <= 32'h0;
      end
      else
      begin
         if (wr_ctrl && !busy)
         begin
            write_prot_n <= reg_wdata[CTRL_WP];
            spare_region_enable_n <= !reg_wdata[CTRL_SPARE];
            err <= refuse || bad_sp || bad_wp;
         end
         if (reg_wr && reg_addr == REG_ADDR && !busy)
            addr <= reg_wdata[ADDR_W-1:0];
         else if (ptr_step && state == ST_DOUT && op == HOP_READ && xfer_left <= 10'h1)
            addr[ADDR_BIT8] <= 1'b0;
         if (reg_wr && reg_addr == REG_COUNT && !busy)
            count <= reg_wdata[PTR_W-1:0];
         reg_rdata <= 32'h0;
         if (reg_rd)
         begin
            unique case (reg_addr)
               REG_CTRL:   reg_rdata <= {25'h0, op, 1'b0, !spare_region_enable_n,
                                         write_prot_n, busy};
               REG_ADDR:   reg_rdata <= {9'h0, addr};
               REG_COUNT:  reg_rdata <= {22'h0, count};
               REG_STATUS: reg_rdata <= {29'h0, err, dev_ready, busy};
               REG_BUF:    reg_rdata <= {24'h0, mem_rd};
               REG_BUFPTR: reg_rdata <= {22'h0, buf_ptr};
               default:    reg_rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule // nfc_ctrl

// ### src/nfc_page_mem.sv
// Page buffer memory with registered read data
`timescale 1ns/1ns
module nfc_page_mem
   import nfc_pkg::*;
(
   input  wire logic                      sys_clk,
   input  wire logic                      wr_en,
   input  wire logic [nfc_pkg::PTR_W-1:0] wr_addr,
   input  wire logic [7:0]                wr_data,
   input  wire logic [nfc_pkg::PTR_W-1:0] rd_addr,
   output logic      [7:0]                rd_data
);
   logic [7:0] mem [0:PAGE_BYTES-1];

   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // nfc_page_mem

// ### src/nfc_pkg.sv
// Constants and types shared by the NAND flash command port controller
package nfc_pkg;
   // Device opcodes
   localparam logic [7:0] OP_READ_A   = 8'h00;
   localparam logic [7:0] OP_READ_B   = 8'h01;
   localparam logic [7:0] OP_READ_SP  = 8'h50;
   localparam logic [7:0] OP_IDENT    = 8'h90;
   localparam logic [7:0] OP_RESET    = 8'hFF;
   localparam logic [7:0] OP_PROG     = 8'h80;
   localparam logic [7:0] OP_PROG_GO  = 8'h10;
   localparam logic [7:0] OP_ERASE    = 8'h60;
   localparam logic [7:0] OP_ERASE_GO = 8'hD0;
   localparam logic [7:0] OP_STATUS   = 8'h70;

   // Software register offsets
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_ADDR    = 4'h1;
   localparam logic [3:0] REG_COUNT   = 4'h2;
   localparam logic [3:0] REG_STATUS  = 4'h3;
   localparam logic [3:0] REG_BUF     = 4'h4;
   localparam logic [3:0] REG_BUFPTR  = 4'h5;

   // Control register fields
   localparam int CTRL_GO      = 0;
   localparam int CTRL_WP      = 1;
   localparam int CTRL_SPARE   = 2;
   localparam int CTRL_OP_LSB  = 4;
   localparam int CTRL_OP_W    = 3;

   // Status register fields
   localparam int STAT_BUSY    = 0;
   localparam int STAT_RB      = 1;
   localparam int STAT_ERR     = 2;

   // Page geometry
   localparam int PAGE_BYTES   = 528;
   localparam int PTR_W        = 10;
   localparam int ADDR_W       = 23;
   localparam int ADDR_BIT8    = 8;

   // Host operations
   typedef enum logic [2:0] {
      HOP_READ   = 3'h0,
      HOP_SPARE  = 3'h1,
      HOP_IDENT  = 3'h2,
      HOP_PROG   = 3'h3,
      HOP_ERASE  = 3'h4,
      HOP_STATUS = 3'h5,
      HOP_RESET  = 3'h6
   } nfc_op_t;

   // Timing: one strobe phase is two system cycles
   localparam int CLK_NS        = 4;
   localparam int PHASE_NS      = 8;
   localparam int PHASE_CYC     = (PHASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int XFER_US       = 10;
   localparam int XFER_CYC      = XFER_US * 1000 / CLK_NS;
   localparam int RB_SETTLE_CYC = 8;
endpackage

// ### tb/nfc_checker.sv
// Pin-level assertions on the flash command port controller
`timescale 1ns/1ns
module nfc_checker
   import nfc_pkg::*;
(
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   input wire logic       cmd_latch,
   input wire logic       addr_latch,
   input wire logic       chip_sel_n,
   input wire logic       write_strobe_n,
   input wire logic       read_strobe_n,
   input wire logic       write_prot_n,
   input wire logic       spare_region_enable_n,
   input wire logic [7:0] shared_io_bus_out,
   input wire logic       shared_io_bus_oe,
   input wire logic       ready_busy_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   wire cmd_fall = !write_strobe_n && cmd_latch;

   latch_exclusive_a: assert property (!(cmd_latch && addr_latch))
      else $error("both latch selects high");
   we_select_a: assert property (!write_strobe_n |-> !chip_sel_n && shared_io_bus_oe)
      else $error("write strobe without select or driven bus");
   we_width_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*2] ##1 write_strobe_n)
      else $error("write strobe width wrong");
   we_data_hold_a: assert property ($rose(write_strobe_n) |->
      $stable(shared_io_bus_out) && $stable(cmd_latch) && $stable(addr_latch))
      else $error("byte or latch moved at strobe rise");
   re_quiet_a: assert property (!read_strobe_n |-> write_strobe_n && !cmd_latch && !addr_latch
      && !shared_io_bus_oe && !chip_sel_n)
      else $error("bad pin state during data output");
   cmd_ready_a: assert property ($fell(write_strobe_n) && cmd_fall && shared_io_bus_out != OP_RESET
      && shared_io_bus_out != OP_STATUS |-> ready_busy_n)
      else $error("command issued while device busy");
   wp_prog_a: assert property ($fell(write_strobe_n) && cmd_fall && (shared_io_bus_out == OP_PROG_GO
      || shared_io_bus_out == OP_ERASE_GO) |-> write_prot_n)
      else $error("program or erase with protection on");
   se_fixed_a: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(spare_region_enable_n))
      else $error("spare enable moved while selected");
endmodule // nfc_checker

// ### tb/nfc_flash_model.sv
// Behavioural flash device answering the controller's pins
`timescale 1ns/1ns
module nfc_flash_model #(
   parameter int         BUSY_NS = 2000,
   parameter logic [7:0] ID_BYTE = 8'h3C // Arbitrary value
)
(
   input wire logic       cmd_latch,
   input wire logic       addr_latch,
   input wire logic       chip_sel_n,
   input wire logic       write_strobe_n,
   input wire logic       read_strobe_n,
   input wire logic       write_prot_n,
   input wire logic       spare_region_enable_n,
   input wire logic [7:0] io_wr,
   output logic     [7:0] io_rd,
   output logic           io_oe,
   output logic           rb_low
);
   logic [7:0]  mem [int];
   logic [7:0]  page [528];
   logic [7:0]  cmd = 8'h00;
   logic [13:0] row = 14'h0;
   logic        half = 1'b0;
   int          col = 0;
   int          acnt = 0;
   event        go_busy;
   initial rb_low = 1'b0;
   always @(posedge write_strobe_n) if (!chip_sel_n)
   begin
      if (cmd_latch && !(rb_low && io_wr != 8'hFF && io_wr != 8'h70))
      begin
         cmd = (io_wr == 8'h50 && spare_region_enable_n) ? 8'h00 : io_wr;
         acnt = (io_wr == 8'h60) ? 1 : 0;
         if (io_wr < 8'h02) half = io_wr[0];
         if (io_wr == 8'h10 && write_prot_n)
         begin
            for (int i = 0; i < 528; i++) mem[row * 528 + i] = page[i];
            -> go_busy;
         end
         if (io_wr == 8'hD0 && write_prot_n)
         begin
            for (int i = 0; i < 16 * 528; i++) mem.delete((row & 14'h3FF0) * 528 + i);
            -> go_busy;
         end
      end
      else if (addr_latch && !cmd_latch)
      begin
         if (acnt == 0) col = (cmd == 8'h50) ? 512 + io_wr[3:0] : {half, io_wr};
         if (acnt == 1) row[7:0] = io_wr;
         if (acnt == 2) row[13:8] = io_wr[5:0];
         acnt++;
         if (acnt == 3 && cmd != 8'h60)
         begin
            for (int i = 0; i < 528; i++)
               page[i] = (cmd != 8'h80 && mem.exists(row * 528 + i)) ? mem[row * 528 + i] : 8'hFF;
            half = 1'b0;
            if (cmd < 8'h60) -> go_busy;
         end
      end
      else if (!cmd_latch)
      begin
         if (!(col > 511 && spare_region_enable_n)) page[col % 528] = io_wr;
         col++;
      end
   end
   always @(negedge read_strobe_n) if (!chip_sel_n)
   begin
      io_rd = (cmd == 8'h90) ? ID_BYTE : (cmd == 8'h70) ? {1'b0, ~rb_low, 6'h0}
            : (col > 511 && spare_region_enable_n) ? 8'hFF : page[col % 528];
      col++;
   end
   assign io_oe = !chip_sel_n && !read_strobe_n;
   // Busy runs on its own, whatever chip select does
   always @(go_busy)
   begin
      rb_low = 1'b1;
      #(BUSY_NS);
      rb_low = 1'b0;
   end
endmodule // nfc_flash_model

// ### tb/tb.sv
// Top testbench for the flash command port controller
`timescale 1ns/1ns
module tb;
   import nfc_pkg::*;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, rv;
   logic        cmd_latch, addr_latch, chip_sel_n, write_strobe_n, read_strobe_n;
   logic        write_prot_n, spare_region_enable_n, shared_io_bus_oe, m_oe, rb_low;
   logic [7:0]  shared_io_bus_out, m_out, shared_io_bus_in;
   logic [7:0]  junk = 8'h00;
   int          mismatches = 0;
   int          checks = 0;
   wire         ready_busy_n = !rb_low; // Pull-up on open drain
   localparam logic [31:0] PG = 32'hA20;
   // Released bus shows a moving pattern, not the last byte
   assign shared_io_bus_in = m_oe ? m_out : shared_io_bus_oe ? shared_io_bus_out : junk;
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) junk <= junk + 8'h01;
   nfc_ctrl i_nfc_ctrl (
      .sys_clk               (sys_clk),
      .sys_rst               (sys_rst),
      .reg_addr              (reg_addr),
      .reg_wdata             (reg_wdata),
      .reg_wr                (reg_wr),
      .reg_rd                (reg_rd),
      .reg_rdata             (reg_rdata),
      .cmd_latch             (cmd_latch),
      .addr_latch            (addr_latch),
      .chip_sel_n            (chip_sel_n),
      .write_strobe_n        (write_strobe_n),
      .read_strobe_n         (read_strobe_n),
      .write_prot_n          (write_prot_n),
      .spare_region_enable_n (spare_region_enable_n),
      .shared_io_bus_in      (shared_io_bus_in),
      .shared_io_bus_out     (shared_io_bus_out),
      .shared_io_bus_oe      (shared_io_bus_oe),
      .ready_busy_n          (ready_busy_n)
   );
   nfc_flash_model i_nfc_flash_model (
      .cmd_latch             (cmd_latch),
      .addr_latch            (addr_latch),
      .chip_sel_n            (chip_sel_n),
      .write_strobe_n        (write_strobe_n),
      .read_strobe_n         (read_strobe_n),
      .write_prot_n          (write_prot_n),
      .spare_region_enable_n (spare_region_enable_n),
      .io_wr                 (shared_io_bus_out),
      .io_rd                 (m_out),
      .io_oe                 (m_oe),
      .rb_low                (rb_low)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
   task automatic run(input logic [31:0] ctrl, input bit err);
      wr(REG_CTRL, ctrl);
      for (int i = 0; i < 4000; i++)
      begin
         rd(REG_STATUS, rv);
         if (rv[STAT_BUSY] === 1'b0) break;
      end
      chk(rv & (err ? 32'h7 : 32'h3), err ? 32'h6 : 32'h2);
   endtask
   task automatic rdback(input logic [31:0] a, input logic [7:0] b, input logic [7:0] s);
      wr(REG_ADDR, a);
      wr(REG_COUNT, 32'h4);
      run(32'h03, 1'b0);
      wr(REG_BUFPTR, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         rd(REG_BUF, rv);
         chk(rv[7:0], b + s * i);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      #200000;
      mismatches++;
      tally_and_finish;
   end
   initial
   begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(REG_STATUS, rv);
      chk(rv, 32'h2);
      rd(4'hF, rv);
      chk(rv, 32'h0);
      wr(REG_BUFPTR, 32'h0);
      for (int i = 0; i < 4; i++) wr(REG_BUF, 32'hC0 + i);
      wr(REG_ADDR, PG);
      wr(REG_COUNT, 32'h4);
      run(32'h33, 1'b0);
      rdback(PG, 8'hC0, 8'h01);
      rdback(PG | 32'h100, 8'hFF, 8'h00);
      rd(REG_ADDR, rv);
      chk(rv, PG);
      run(32'h43, 1'b0);
      rdback(PG, 8'hFF, 8'h00);
      wr(REG_ADDR, PG);
      run(32'h31, 1'b1);
      rdback(PG, 8'hFF, 8'h00);
      run(32'h11, 1'b1);
      wr(REG_COUNT, 32'h1);
      run(32'h23, 1'b0);
      wr(REG_BUFPTR, 32'h0);
      rd(REG_BUF, rv);
      chk(rv[7:0], 8'h3C);
      run(32'h17, 1'b0);
      wr(REG_BUFPTR, 32'h0);
      rd(REG_BUF, rv);
      chk(rv[7:0], 8'hFF);
      run(32'h53, 1'b0);
      wr(REG_BUFPTR, 32'h0);
      rd(REG_BUF, rv);
      chk(rv[7:0], 8'h40);
      run(32'h63, 1'b0);
      tally_and_finish;
   end
endmodule // tb

bind nfc_ctrl nfc_checker i_nfc_checker (
   .sys_clk               (sys_clk),
   .sys_rst               (sys_rst),
   .cmd_latch             (cmd_latch),
   .addr_latch            (addr_latch),
   .chip_sel_n            (chip_sel_n),
   .write_strobe_n        (write_strobe_n),
   .read_strobe_n         (read_strobe_n),
   .write_prot_n          (write_prot_n),
   .spare_region_enable_n (spare_region_enable_n),
   .shared_io_bus_out     (shared_io_bus_out),
   .shared_io_bus_oe      (shared_io_bus_oe),
   .ready_busy_n          (ready_busy_n)
);
